// [logic/tsst_defines.svh]
// Notes on behaviour
// R1 - Per-camera trigger-to-exposure count, signed -4 to 511, 30 us each, default 0.
// R2 - Delay is count times 30 us plus 122 us plus camera-kind offset.
// R3 - Trigger source waits until the flash strobe pulse has gone inactive.
// R4 - Controller starts no new acquisition during a strobe pulse, else it may drop.
// R5 - One common selection gives the shared lines to strobe or exposure-end, never both.
// R6 - Exposure-end outputs 0 to 7 are indexed by acquisition line number.
// R7 - Flash strobe outputs 0 to 7 are indexed by physical connector number.
// R8 - Unconnected option on drives strobes without a camera; off gates by connection.
// R9 - Exposure-end starts after per-line delay 0 to 1000 us, 10 us steps, default 0.
// R10 - Exposure-end width 40 to 10000 us in 10 us steps, default 5000 us.
// R11 - Per-line polarity: positive goes off to on, negative on to off; positive default.
// R12 - Multi-exposure capture gives one exposure-end pulse per captured image.
// R13 - Live view gives one exposure-end pulse per captured live frame.
// R14 - Function selection comes from line 0; unconnected option is held per line.
// R15 - Controller starts no new acquisition until the exposure-end pulse completes.
// R16 - Up to 8 cameras on large controllers, up to 4 on small ones.
// R17 - All delays and widths run on one free-running 1 us tick.
`ifndef TSST_DEFINES_SVH
`define TSST_DEFINES_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define TSST_CLOCK_NS        8
`define TSST_TICK_NS         1000
`define TSST_TICK_CYCLES     (`TSST_TICK_NS / `TSST_CLOCK_NS)
`define TSST_COUNT_STEP_US   30
`define TSST_BASE_US         122
`define TSST_OFS_STD_US      120
`define TSST_OFS_SLOW_US     470
`define TSST_OFS_LARGE_US    1123
`define TSST_END_STEP_US     10
`define TSST_END_DELAY_MAX_US 1000
`define TSST_END_WIDTH_MIN_US 40
`define TSST_END_WIDTH_MAX_US 10000
`define TSST_END_WIDTH_DEF_US 5000
`define TSST_COUNT_MIN       (-16'sd4)
`define TSST_COUNT_MAX       (16'sd511)
`define TSST_MAX_LINES       8

// ----------------------------------------
// Register map and fields
// ----------------------------------------
`define TSST_CAM_BASE        8'h10
`define TSST_LINE_BASE       8'h40
`define TSST_STATUS_ADDR     8'h80
`define TSST_REG_STRIDE      8'h04
`define TSST_KIND_LSB        16
`define TSST_WIDTH_LSB       8
`define TSST_NEG_BIT         20
`define TSST_UNCONN_BIT      21
`define TSST_SEL_BIT         24

`endif

// [logic/tsst_pkg.sv]
package tsst_pkg;

  // Exposure-end sequencer states
  typedef enum logic [1:0] {
    TSST_IDLE,
    TSST_WAIT,
    TSST_PULSE
  } tsst_end_state_type;

  // Camera kind picks the fixed exposure offset
  typedef enum logic [1:0] {
    TSST_CAM_STD,
    TSST_CAM_SLOW,
    TSST_CAM_LARGE
  } tsst_cam_kind_type;

endpackage : tsst_pkg

// [logic/tsst_timing.sv]
// Chosen here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/10ps
`include "tsst_defines.svh"

module tsst_timing #(
  parameter int NUM_LINES = `TSST_MAX_LINES // R16
) (
  input  wire logic                 clock,
  input  wire logic                 rst_n,
  input  wire logic [7:0]           addr,
  input  wire logic [31:0]          wdata,
  input  wire logic                 wr,
  input  wire logic                 rd,
  output logic      [31:0]          rdata,
  input  wire logic [NUM_LINES-1:0] trigger_in,
  input  wire logic [NUM_LINES-1:0] exposure_done_in,
  input  wire logic [NUM_LINES-1:0] strobe_request_in,
  input  wire logic [NUM_LINES-1:0] camera_connected_in,
  output logic      [NUM_LINES-1:0] exposure_start_out,
  output logic      [NUM_LINES-1:0] flash_strobe_out,
  output logic      [NUM_LINES-1:0] exposure_end_out
);

  // ----------------------------------------
  // Functions
  // ----------------------------------------

  // Trigger-to-exposure time in microseconds
  function automatic logic [15:0] tsst_trig_us(input logic [9:0] cnt, input logic [1:0] kind);
    int s;
    int ofs;
    case (kind)
      2'(tsst_pkg::TSST_CAM_SLOW):  ofs = `TSST_OFS_SLOW_US;
      2'(tsst_pkg::TSST_CAM_LARGE): ofs = `TSST_OFS_LARGE_US;
      default:                      ofs = `TSST_OFS_STD_US;
    endcase
    s = int'($signed(cnt)) * `TSST_COUNT_STEP_US + `TSST_BASE_US + ofs; // R2
    return 16'(s);
  endfunction : tsst_trig_us

  // Steps of 10 us turned into microsecond ticks
  function automatic logic [13:0] tsst_steps_us(input logic [9:0] steps);
    return 14'(int'(steps) * `TSST_END_STEP_US);
  endfunction : tsst_steps_us

  // Trigger count kept inside its legal range
  function automatic logic [9:0] tsst_clamp_count(input logic [15:0] w);
    logic signed [15:0] v;
    v = $signed(w);
    if (v < `TSST_COUNT_MIN) begin
      v = `TSST_COUNT_MIN;
    end else if (v > `TSST_COUNT_MAX) begin
      v = `TSST_COUNT_MAX;
    end
    return v[9:0];
  endfunction : tsst_clamp_count

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------

  logic [NUM_LINES-1:0] trig_m;
  logic [NUM_LINES-1:0] trig_s;
  logic [NUM_LINES-1:0] trig_p;
  logic [NUM_LINES-1:0] done_m;
  logic [NUM_LINES-1:0] done_s;
  logic [NUM_LINES-1:0] done_p;
  logic [NUM_LINES-1:0] req_m;
  logic [NUM_LINES-1:0] req_s;
  logic [NUM_LINES-1:0] conn_m;
  logic [NUM_LINES-1:0] conn_s;
  logic [NUM_LINES-1:0] trig_edge;
  logic [NUM_LINES-1:0] done_edge;

  // Two stages per pin; edges compare the second stage with a third, delayed copy
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      trig_m <= '0;
      trig_s <= '0;
      trig_p <= '0;
      done_m <= '0;
      done_s <= '0;
      done_p <= '0;
      req_m  <= '0;
      req_s  <= '0;
      conn_m <= '0;
      conn_s <= '0;
    end else begin
      trig_m <= trigger_in;
      trig_s <= trig_m;
      trig_p <= trig_s;
      done_m <= exposure_done_in;
      done_s <= done_m;
      done_p <= done_s;
      req_m  <= strobe_request_in;
      req_s  <= req_m;
      conn_m <= camera_connected_in;
      conn_s <= conn_m;
    end
  end

  assign trig_edge = trig_s & ~trig_p;
  assign done_edge = done_s & ~done_p; // R12 R13

  // ----------------------------------------
  // Microsecond tick
  // ----------------------------------------

  logic [6:0] pre_cnt;
  logic [6:0] next_pre_cnt;
  logic       tick;
  logic       next_tick;

  // Free-running, so a delay may end up to one tick early
  always_comb begin
    next_tick    = 1'b0;
    next_pre_cnt = pre_cnt + 7'h01;
    if (pre_cnt == 7'(`TSST_TICK_CYCLES - 1)) begin
      next_pre_cnt = 7'h00;
      next_tick    = 1'b1; // R17
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pre_cnt <= 7'h00;
      tick    <= 1'b0;
    end else begin
      pre_cnt <= next_pre_cnt;
      tick    <= next_tick;
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------

  logic [9:0]           trig_count [NUM_LINES];
  logic [1:0]           cam_kind   [NUM_LINES];
  logic [6:0]           end_delay  [NUM_LINES];
  logic [9:0]           end_width  [NUM_LINES];
  logic [NUM_LINES-1:0] end_neg;
  logic [NUM_LINES-1:0] unconn_en;
  logic                 sel_end;
  logic [9:0]           next_trig_count [NUM_LINES];
  logic [1:0]           next_cam_kind   [NUM_LINES];
  logic [6:0]           next_end_delay  [NUM_LINES];
  logic [9:0]           next_end_width  [NUM_LINES];
  logic [NUM_LINES-1:0] next_end_neg;
  logic [NUM_LINES-1:0] next_unconn_en;
  logic                 next_sel_end;
  logic [31:0]          next_rdata;

  // Writes clamp the count, delay and width fields into their legal ranges; camera kind is stored as written
  always_comb begin
    next_trig_count = trig_count;
    next_cam_kind   = cam_kind;
    next_end_delay  = end_delay;
    next_end_width  = end_width;
    next_end_neg    = end_neg;
    next_unconn_en  = unconn_en;
    next_sel_end    = sel_end;
    for (int i = 0; i < NUM_LINES; i++) begin
      if (wr && addr == 8'(`TSST_CAM_BASE + `TSST_REG_STRIDE * i)) begin
        next_trig_count[i] = tsst_clamp_count(wdata[15:0]); // R1
        next_cam_kind[i]   = wdata[`TSST_KIND_LSB +: 2];
      end
      if (wr && addr == 8'(`TSST_LINE_BASE + `TSST_REG_STRIDE * i)) begin
        next_end_delay[i] = wdata[6:0];
        if (wdata[6:0] > 7'(`TSST_END_DELAY_MAX_US / `TSST_END_STEP_US)) begin
          next_end_delay[i] = 7'(`TSST_END_DELAY_MAX_US / `TSST_END_STEP_US); // R9
        end
        next_end_width[i] = wdata[`TSST_WIDTH_LSB +: 10];
        if (wdata[`TSST_WIDTH_LSB +: 10] < 10'(`TSST_END_WIDTH_MIN_US / `TSST_END_STEP_US)) begin
          next_end_width[i] = 10'(`TSST_END_WIDTH_MIN_US / `TSST_END_STEP_US); // R10
        end else if (wdata[`TSST_WIDTH_LSB +: 10] > 10'(`TSST_END_WIDTH_MAX_US / `TSST_END_STEP_US)) begin
          next_end_width[i] = 10'(`TSST_END_WIDTH_MAX_US / `TSST_END_STEP_US); // R10
        end
        next_end_neg[i]   = wdata[`TSST_NEG_BIT]; // R11
        next_unconn_en[i] = wdata[`TSST_UNCONN_BIT]; // R14
        if (i == 0) begin
          next_sel_end = wdata[`TSST_SEL_BIT]; // R14
        end
      end
    end
  end

  logic [NUM_LINES-1:0] trig_busy;
  logic [NUM_LINES-1:0] end_busy;

  // Read data stand one cycle, zero otherwise and on unmapped offsets
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (rd) begin
      for (int i = 0; i < NUM_LINES; i++) begin
        if (addr == 8'(`TSST_CAM_BASE + `TSST_REG_STRIDE * i)) begin
          next_rdata[9:0]                 = trig_count[i];
          next_rdata[15:10]               = {6{trig_count[i][9]}};
          next_rdata[`TSST_KIND_LSB +: 2] = cam_kind[i];
        end
        if (addr == 8'(`TSST_LINE_BASE + `TSST_REG_STRIDE * i)) begin
          next_rdata[6:0]                    = end_delay[i];
          next_rdata[`TSST_WIDTH_LSB +: 10]  = end_width[i];
          next_rdata[`TSST_NEG_BIT]          = end_neg[i];
          next_rdata[`TSST_UNCONN_BIT]       = unconn_en[i];
          next_rdata[`TSST_SEL_BIT]          = (i == 0) ? sel_end : 1'b0;
        end
      end
      if (addr == `TSST_STATUS_ADDR) begin
        next_rdata[NUM_LINES-1:0]    = trig_busy;
        next_rdata[8 +: NUM_LINES]   = end_busy;
        next_rdata[16 +: NUM_LINES]  = conn_s;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_LINES; i++) begin
        trig_count[i] <= 10'h000; // R1
        cam_kind[i]   <= 2'h0;
        end_delay[i]  <= 7'h00;
        end_width[i]  <= 10'(`TSST_END_WIDTH_DEF_US / `TSST_END_STEP_US);
      end
      end_neg   <= '0;
      unconn_en <= '0;
      sel_end   <= 1'b0; // R5
      rdata     <= 32'h0000_0000;
    end else begin
      trig_count <= next_trig_count;
      cam_kind   <= next_cam_kind;
      end_delay  <= next_end_delay;
      end_width  <= next_end_width;
      end_neg    <= next_end_neg;
      unconn_en  <= next_unconn_en;
      sel_end    <= next_sel_end;
      rdata      <= next_rdata;
    end
  end

  // ----------------------------------------
  // Trigger delay per camera
  // ----------------------------------------

  logic [15:0]          trig_wait      [NUM_LINES];
  logic [15:0]          next_trig_wait [NUM_LINES];
  logic [NUM_LINES-1:0] next_start;
  logic [15:0]          trig_load_val0;

  assign trig_load_val0 = tsst_trig_us(trig_count[0], cam_kind[0]);

  // A trigger during a running delay is ignored
  always_comb begin
    next_trig_wait = trig_wait;
    next_start     = '0;
    for (int i = 0; i < NUM_LINES; i++) begin
      trig_busy[i] = (trig_wait[i] != 16'h0000);
      if (trig_edge[i] && !trig_busy[i]) begin
        next_trig_wait[i] = tsst_trig_us(trig_count[i], cam_kind[i]); // R1 R17
      end else if (tick && trig_busy[i]) begin
        next_trig_wait[i] = trig_wait[i] - 16'h0001;
        next_start[i]     = (trig_wait[i] == 16'h0001); // R1
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_LINES; i++) begin
        trig_wait[i] <= 16'h0000;
      end
      exposure_start_out <= '0;
    end else begin
      trig_wait          <= next_trig_wait;
      exposure_start_out <= next_start;
    end
  end

  // ----------------------------------------
  // Exposure-end sequencer per line
  // ----------------------------------------

  tsst_pkg::tsst_end_state_type end_state      [NUM_LINES];
  tsst_pkg::tsst_end_state_type next_end_state [NUM_LINES];
  logic [13:0]                  end_cnt        [NUM_LINES];
  logic [13:0]                  next_end_cnt   [NUM_LINES];
  logic [NUM_LINES-1:0]         next_end_out;
  logic [NUM_LINES-1:0]         next_strobe;
  logic [13:0]                  width_ticks0;

  assign width_ticks0 = tsst_steps_us(end_width[0]);

  // Leaving exposure-end mode drops any pulse in flight
  always_comb begin
    next_end_state = end_state;
    next_end_cnt   = end_cnt;
    next_end_out   = '0;
    next_strobe    = '0;
    for (int i = 0; i < NUM_LINES; i++) begin
      case (end_state[i])
        tsst_pkg::TSST_IDLE: begin
          if (done_edge[i] && end_delay[i] == 7'h00) begin
            next_end_state[i] = tsst_pkg::TSST_PULSE; // R9
            next_end_cnt[i]   = tsst_steps_us(end_width[i]); // R10
          end else if (done_edge[i]) begin
            next_end_state[i] = tsst_pkg::TSST_WAIT;
            next_end_cnt[i]   = tsst_steps_us({3'b000, end_delay[i]}); // R9
          end
        end
        tsst_pkg::TSST_WAIT: begin
          if (tick && end_cnt[i] == 14'h0001) begin
            next_end_state[i] = tsst_pkg::TSST_PULSE; // R9
            next_end_cnt[i]   = tsst_steps_us(end_width[i]); // R10
          end else if (tick) begin
            next_end_cnt[i] = end_cnt[i] - 14'h0001;
          end
        end
        tsst_pkg::TSST_PULSE: begin
          if (tick && end_cnt[i] == 14'h0001) begin
            next_end_state[i] = tsst_pkg::TSST_IDLE; // R10
            next_end_cnt[i]   = 14'h0000;
          end else if (tick) begin
            next_end_cnt[i] = end_cnt[i] - 14'h0001;
          end
        end
        default: begin
          next_end_state[i] = tsst_pkg::TSST_IDLE;
          next_end_cnt[i]   = 14'h0000;
        end
      endcase
      if (!sel_end) begin
        next_end_state[i] = tsst_pkg::TSST_IDLE; // R5
        next_end_cnt[i]   = 14'h0000;
      end
      end_busy[i] = (end_state[i] != tsst_pkg::TSST_IDLE);
      // Line i drives exposure-end i, connector i drives strobe i
      if (sel_end) begin
        next_end_out[i] = (next_end_state[i] == tsst_pkg::TSST_PULSE) ^ end_neg[i]; // R5 R6 R11
      end else begin
        next_strobe[i] = req_s[i] && (conn_s[i] || unconn_en[i]); // R5 R7 R8
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_LINES; i++) begin
        end_state[i] <= tsst_pkg::TSST_IDLE;
        end_cnt[i]   <= 14'h0000;
      end
      exposure_end_out <= '0;
      flash_strobe_out <= '0;
    end else begin
      end_state        <= next_end_state;
      end_cnt          <= next_end_cnt;
      exposure_end_out <= next_end_out;
      flash_strobe_out <= next_strobe;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------

  default clocking tsst_cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  tick_period_a: assert property ( // R17
    tick |=> !tick [*8]
  ) else $error("tick came too soon");

  trig_load_a: assert property ( // R2
    (trig_edge[0] && trig_wait[0] == 16'h0000) |=> trig_wait[0] == $past(trig_load_val0)
  ) else $error("trigger delay loaded wrong value");

  start_after_wait_a: assert property ( // R1
    exposure_start_out[0] |-> (trig_wait[0] == 16'h0000) && $past(tick) && ($past(trig_wait[0]) == 16'h0001)
  ) else $error("exposure start without delay expiry");

  strobe_idle_a: assert property ( // R5
    $past(sel_end) |-> flash_strobe_out == '0
  ) else $error("strobe driven in exposure-end mode");

  end_idle_a: assert property ( // R5
    !$past(sel_end) |-> exposure_end_out == '0
  ) else $error("exposure-end driven in strobe mode");

  strobe_gate_a: assert property ( // R8
    flash_strobe_out[0] |-> $past(conn_s[0] || unconn_en[0])
  ) else $error("strobe on unconnected connector");

  end_zero_delay_a: assert property ( // R9
    (sel_end && done_edge[0] && end_state[0] == tsst_pkg::TSST_IDLE && end_delay[0] == 7'h00)
      |=> end_state[0] == tsst_pkg::TSST_PULSE && end_cnt[0] == $past(width_ticks0)
  ) else $error("zero delay did not start pulse");

  end_wait_a: assert property ( // R9
    (sel_end && end_state[0] == tsst_pkg::TSST_WAIT && tick && end_cnt[0] == 14'h0001)
      |=> end_state[0] == tsst_pkg::TSST_PULSE
  ) else $error("delay expiry did not start pulse");

  end_width_a: assert property ( // R10
    (sel_end && end_state[0] == tsst_pkg::TSST_PULSE && tick && end_cnt[0] == 14'h0001)
      |=> end_state[0] == tsst_pkg::TSST_IDLE
  ) else $error("pulse did not end at width");

  end_polarity_a: assert property ( // R11
    $past(sel_end) |-> exposure_end_out[0] == ((end_state[0] == tsst_pkg::TSST_PULSE) ^ $past(end_neg[0]))
  ) else $error("exposure-end level wrong for polarity");

endmodule : tsst_timing

// [dv/tsst_partner.sv]
`timescale 1ns/10ps

// ----------------------------------------
// Trigger source and camera side model
// ----------------------------------------
module tsst_partner #(
  parameter int NUM_LINES = 8
) (
  input  wire logic                 clock,
  input  wire logic                 rst_n,
  input  wire logic [NUM_LINES-1:0] trig_cmd,
  input  wire logic [NUM_LINES-1:0] done_cmd,
  input  wire logic [NUM_LINES-1:0] flash_strobe_out,
  output logic      [NUM_LINES-1:0] trigger_in,
  output logic      [NUM_LINES-1:0] exposure_done_in
);
  logic [NUM_LINES-1:0] pend_t;
  logic [NUM_LINES-1:0] pend_d;
  logic [2:0]           hold;

  // Pins stay high 4 cycles so the double-flop sync cannot miss them
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pend_t           <= '0;
      pend_d           <= '0;
      hold             <= 3'd0;
      trigger_in       <= '0;
      exposure_done_in <= '0;
    end else if (hold != 3'd0) begin
      hold <= hold - 3'd1;
      if (hold == 3'd1) begin
        trigger_in       <= '0;
        exposure_done_in <= '0;
      end
      pend_t <= pend_t | trig_cmd;
      pend_d <= pend_d | done_cmd;
    end else if (((pend_t & ~flash_strobe_out) | pend_d) != '0) begin
      // A trigger waits while its light is still lit
      trigger_in       <= pend_t & ~flash_strobe_out;
      exposure_done_in <= pend_d;
      pend_t           <= (pend_t & flash_strobe_out) | trig_cmd;
      pend_d           <= done_cmd;
      hold             <= 3'd4;
    end else begin
      pend_t <= pend_t | trig_cmd;
      pend_d <= pend_d | done_cmd;
    end
  end
endmodule : tsst_partner

// [dv/trigger_strobe_shutter_timing_test.sv]
`timescale 1ns/10ps

module trigger_strobe_shutter_timing_test;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [31:0] rdata;
  logic [7:0]  strobe_request_in = 8'h00;
  logic [7:0]  camera_connected_in = 8'h00;
  logic [7:0]  trig_cmd = 8'h00;
  logic [7:0]  done_cmd = 8'h00;
  logic [7:0]  trigger_in, exposure_done_in, exposure_start_out, flash_strobe_out, exposure_end_out;
  logic [7:0]  prev_end = 8'h00;
  logic [31:0] seed = 32'hcee313f9;
  logic [31:0] d;
  int          fails = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  int          t0, k;
  int          st_t[8], st_n[8], e_n[8];
  int          e_t[8][6];
  logic [31:0] cw[8] = '{32'h0000_fffc, 32'h0, 32'h0001_fffc, 32'h0003_0002,
                         32'h0000_0258, 32'h0000_fff6, 32'h0002_0000, 32'h0000_01ff};
  int          cu[4] = '{-4, 0, -4, 2};
  int          ck[4] = '{0, 0, 1, 3};

  // 8 ns period
  always #4 clock = ~clock;

  tsst_timing #(.NUM_LINES(8)) u_tsst_timing (
    .clock(clock), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .trigger_in(trigger_in), .exposure_done_in(exposure_done_in), .strobe_request_in(strobe_request_in),
    .camera_connected_in(camera_connected_in), .exposure_start_out(exposure_start_out),
    .flash_strobe_out(flash_strobe_out), .exposure_end_out(exposure_end_out));

  tsst_partner #(.NUM_LINES(8)) u_tsst_partner (
    .clock(clock), .rst_n(rst_n), .trig_cmd(trig_cmd), .done_cmd(done_cmd),
    .flash_strobe_out(flash_strobe_out), .trigger_in(trigger_in), .exposure_done_in(exposure_done_in));

  // Monitor on the falling edge, away from the registered output updates
  always @(negedge clock) begin
    cyc <= cyc + 1;
    for (int i = 0; i < 8; i++) begin
      if (exposure_start_out[i] === 1'b1) begin
        st_t[i] <= cyc;
        st_n[i] <= st_n[i] + 1;
      end
      if (exposure_end_out[i] !== prev_end[i]) begin
        if (e_n[i] < 6) e_t[i][e_n[i]] <= cyc;
        e_n[i] <= e_n[i] + 1;
      end
    end
    prev_end <= exposure_end_out;
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs

  // Microseconds from trigger to exposure start; kind 3 falls back to the standard offset
  function automatic int dly_us(input int cnt, input int kind);
    return cnt * 30 + 122 + ((kind == 1) ? 470 : (kind == 2) ? 1123 : 120);
  endfunction : dly_us

  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    cmp_count++;
    if (seen !== want) begin
      fails++;
      $display("BAD t=%0t seen %h want %h", $time, seen, want);
    end
  endtask : chk

  // Tick is free-running, so a count lands within one tick window
  task automatic win(input int v, input int lo, input int hi);
    chk({31'd0, (v >= lo) && (v <= hi)}, 32'd1);
  endtask : win

  task automatic wreg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask : wreg

  task automatic rreg(input logic [7:0] a, output logic [31:0] v);
    @(posedge clock);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 v = rdata;
  endtask : rreg

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : stop_test

  // Whole run is about 86k cycles, the slow camera kind alone about 59k
  initial begin
    repeat (95000) @(posedge clock);
    fails++;
    $display("BAD t=%0t watchdog expired", $time);
    stop_test();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    foreach (st_n[i]) begin
      st_n[i] = 0;
      e_n[i] = 0;
    end
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    rreg(8'h10, d); chk(d, 32'h0);
    rreg(8'h44, d); chk(d, 32'h0001_f400);
    rreg(8'h40, d); chk(d, 32'h0001_f400);
    wreg(8'h0c, 32'hffff_ffff);
    rreg(8'h0c, d); chk(d, 32'h0);
    @(posedge clock); #1 chk(rdata, 32'h0);
    $display("register defaults done");

    // Camera counts, clamps at both ends and all kinds
    for (int i = 0; i < 8; i++) wreg(8'h10 + 8'(4 * i), cw[i]);
    rreg(8'h20, d); chk(d[15:0], 16'h01ff);
    rreg(8'h24, d); chk(d[15:0], 16'hfffc);
    rreg(8'h28, d); chk(d[17:16], 2'd2);
    @(posedge clock);
    trig_cmd <= 8'h0f;
    t0 = cyc;
    @(posedge clock);
    trig_cmd <= 8'h00;
    // Delays just loaded show as running in the status word
    repeat (5) @(posedge clock);
    rreg(8'h80, d); chk(d, 32'h0000_000f);
    for (k = 0; k < 70000 && st_n[2] == 0; k++) @(posedge clock);
    for (int i = 0; i < 4; i++) begin
      win(st_t[i] - t0, (dly_us(cu[i], ck[i]) - 1) * 125, dly_us(cu[i], ck[i]) * 125 + 12);
      chk(st_n[i], 32'd1);
    end
    for (int i = 4; i < 8; i++) chk(st_n[i], 32'd0);
    $display("trigger delay done");

    // Exposure-end mode: line 1 delayed, line 2 immediate and inverted
    wreg(8'h40, 32'h0101_f400);
    wreg(8'h44, 32'h0000_0403);
    wreg(8'h48, 32'h0010_0200);
    wreg(8'h4c, 32'h0100_0000);
    rreg(8'h48, d); chk(d, 32'h0010_0400);
    rreg(8'h4c, d); chk(d, 32'h0000_0400);
    @(posedge clock);
    strobe_request_in   <= 8'hff;
    camera_connected_in <= 8'hff;
    repeat (6) @(posedge clock);
    #1 chk(flash_strobe_out, 8'h00);
    chk(exposure_end_out, 8'h04);
    foreach (e_n[i]) e_n[i] = 0;
    @(posedge clock);
    done_cmd <= 8'h06;
    t0 = cyc;
    @(posedge clock);
    done_cmd <= 8'h00;
    // Line 1 waiting and line 2 pulsing both read busy, all connectors present
    repeat (5) @(posedge clock);
    rreg(8'h80, d); chk(d, 32'h00ff_0600);
    for (k = 0; k < 12000 && e_n[1] < 2; k++) @(posedge clock);
    win(e_t[1][0] - t0, 29 * 125, 30 * 125 + 12);
    win(e_t[1][1] - e_t[1][0], 39 * 125, 40 * 125 + 2);
    win(e_t[2][0] - t0, 0, 12);
    win(e_t[2][1] - e_t[2][0], 39 * 125, 40 * 125 + 2);
    for (int i = 0; i < 8; i++) if (i != 1 && i != 2) chk(e_n[i], 32'd0);
    // Next image only once the previous pulse is over
    repeat (2) begin
      @(posedge clock);
      done_cmd <= 8'h02;
      t0 = e_n[1];
      @(posedge clock);
      done_cmd <= 8'h00;
      for (k = 0; k < 12000 && e_n[1] < t0 + 2; k++) @(posedge clock);
    end
    chk(e_n[1], 32'd6);
    $display("exposure end done");

    // Strobe mode with per-line unconnected option on lines 3 and 6
    wreg(8'h40, 32'h0001_f400);
    wreg(8'h4c, 32'h0020_0400);
    wreg(8'h58, 32'h0021_f400);
    for (int n = 0; n < 9; n++) begin
      seed = xs(seed);
      d = (n == 0) ? 32'h0000_00ff : seed;
      @(posedge clock);
      strobe_request_in   <= d[7:0];
      camera_connected_in <= d[15:8];
      repeat (5) @(posedge clock);
      #1 chk(flash_strobe_out, d[7:0] & (d[15:8] | 8'h48));
      chk(exposure_end_out, 8'h00);
    end
    $display("strobe done");
    stop_test();
  end
endmodule : trigger_strobe_shutter_timing_test
